/* test_timer8_counter_compare_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module test_timer8_counter_compare_unit;
  // ==========
  // Signals
  logic       sys_clk;
  logic       rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       ovf_irq_ack;
  logic       cmp_irq_ack;
  logic       io_clock;
  logic       oscillator_pin_one;
  logic       oscillator_pin_two;
  logic       ovf_irq;
  logic       cmp_irq;
  logic       pin_out;
  logic       pin_oe;
  int         errors;
  int         compares;
  localparam logic [2:0] ca = timer8_pkg::ctrl_addr;
  localparam logic [2:0] na = timer8_pkg::count_addr;
  localparam logic [2:0] pa = timer8_pkg::compare_addr;
  localparam logic [2:0] fa = timer8_pkg::flag_addr;
  localparam logic [2:0] ea = timer8_pkg::irq_enable_addr;
  localparam logic [2:0] sa = timer8_pkg::async_addr;
  localparam logic [2:0] qa = timer8_pkg::pin_addr;

  timer8_counter_compare_unit timer8_counter_compare_unit_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ovf_irq_ack(ovf_irq_ack), .cmp_irq_ack(cmp_irq_ack), .io_clock(io_clock),
    .oscillator_pin_one(oscillator_pin_one), .oscillator_pin_two(oscillator_pin_two),
    .ovf_irq(ovf_irq), .cmp_irq(cmp_irq), .pin_out(pin_out), .pin_oe(pin_oe)
  );

  always #12.5 sys_clk = ~sys_clk;

  // ==========
  // Bus and compare tasks; all but chk8 and tally_and_finish start and end on a rising edge
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    // Idle edge so a following strobe is never driven in the same step
    @(posedge sys_clk);
  endtask : wr

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk8(reg_rdata, exp);
    @(posedge sys_clk);
  endtask : chk_rd

  // Outputs are registered twice behind a write, so wait two edges
  task automatic chk_out(input logic [7:0] exp);
    repeat (2) @(posedge sys_clk);
    #1;
    chk8({4'h0, ovf_irq, cmp_irq, pin_oe, pin_out}, exp);
    @(posedge sys_clk);
  endtask : chk_out

  // Long phases cover the synchroniser delay of either source
  task automatic pulse(input logic osc, input int n);
    repeat (n)
    begin
      io_clock           <= !osc;
      oscillator_pin_one <= osc;
      repeat (6) @(posedge sys_clk);
      io_clock           <= 1'b0;
      oscillator_pin_one <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
  endtask : pulse

  task automatic tally_and_finish();
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // ==========
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 8; i++)
    begin
      chk_rd(3'(i), 8'h00);
    end
    wr(na, 8'h10);
    pulse(1'b0, 3);
    chk_rd(na, 8'h10);
  endtask : t_reset

  task automatic t_normal();
    wr(na, 8'hfe);
    wr(ca, 8'h01);
    pulse(1'b0, 1);
    chk_rd(na, 8'hff);
    chk_rd(fa, 8'h00);
    pulse(1'b0, 1);
    chk_rd(na, 8'h00);
    chk_rd(fa, 8'h01);
    wr(ea, 8'h01);
    chk_out(8'h08);
    ovf_irq_ack <= 1'b1;
    @(posedge sys_clk);
    ovf_irq_ack <= 1'b0;
    chk_out(8'h00);
    wr(ea, 8'h00);
  endtask : t_normal

  task automatic t_async();
    wr(sa, 8'h01);
    wr(na, 8'h40);
    pulse(1'b0, 1);
    chk_rd(na, 8'h40);
    pulse(1'b1, 1);
    chk_rd(na, 8'h41);
    wr(sa, 8'h00);
    pulse(1'b0, 1);
    chk_rd(na, 8'h42);
  endtask : t_async

  task automatic t_compare();
    wr(pa, 8'h20);
    wr(na, 8'h20);
    pulse(1'b0, 1);
    chk_rd(na, 8'h21);
    chk_rd(fa, 8'h00);
    wr(na, 8'h1f);
    pulse(1'b0, 1);
    chk_rd(fa, 8'h00);
    pulse(1'b0, 1);
    chk_rd(fa, 8'h02);
    wr(ea, 8'h02);
    chk_out(8'h04);
    wr(fa, 8'h02);
    chk_out(8'h00);
    wr(na, 8'h1f);
    pulse(1'b0, 2);
    chk_out(8'h04);
    cmp_irq_ack <= 1'b1;
    @(posedge sys_clk);
    cmp_irq_ack <= 1'b0;
    chk_out(8'h00);
    wr(ea, 8'h00);
  endtask : t_compare

  task automatic t_output();
    logic [1:0] com [4];
    logic       oc [4];
    com = '{2'h1, 2'h2, 2'h3, 2'h0};
    oc  = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(ca, 8'h00);
    wr(qa, 8'h02);
    chk_out(8'h02);
    for (int i = 0; i < 4; i++)
    begin
      wr(ca, {2'b10, com[i], 4'h0});
      chk_rd(qa, {5'h0, oc[i], 2'h2});
      chk_out({7'h01, (com[i] != 2'h0) ? oc[i] : 1'b0});
    end
    chk_rd(fa, 8'h00);
    chk_rd(na, 8'h21);
    chk_rd(ca, 8'h00);
    wr(ca, 8'hd8);
    chk_rd(qa, 8'h06);
    chk_out(8'h03);
    wr(ca, 8'h00);
    chk_rd(qa, 8'h06);
  endtask : t_output

  task automatic t_modes();
    wr(pa, 8'h03);
    wr(na, 8'h00);
    wr(ca, 8'h41);
    chk_rd(ca, 8'h41);
    pulse(1'b0, 4);
    chk_rd(na, 8'h00);
    chk_rd(fa, 8'h02);
    wr(fa, 8'h03);
    // Fast mode: new compare waits in the buffer, old one still matches
    wr(ca, 8'h48);
    wr(pa, 8'h05);
    chk_rd(pa, 8'h05);
    wr(na, 8'h02);
    wr(ca, 8'h49);
    pulse(1'b0, 2);
    chk_rd(na, 8'h04);
    chk_rd(fa, 8'h02);
    // Dual slope: turn at the top, buffer moves to live compare there
    wr(ca, 8'h08);
    wr(na, 8'hfe);
    wr(ca, 8'h09);
    pulse(1'b0, 2);
    chk_rd(na, 8'hfe);
    wr(ca, 8'h00);
    chk_rd(pa, 8'h05);
  endtask : t_modes

  // ==========
  // Main sequence and watchdog
  initial
  begin
    {sys_clk, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {ovf_irq_ack, cmp_irq_ack, io_clock, oscillator_pin_one} = '0;
    errors = 0;
    compares = 0;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_normal();
    t_async();
    t_compare();
    t_output();
    t_modes();
    tally_and_finish();
  end

  // Tests need about 440 cycles; the 8000-cycle limit allows about eighteen times that
  initial
  begin
    #200000;
    errors = errors + 1;
    tally_and_finish();
  end
endmodule : test_timer8_counter_compare_unit
`default_nettype wire

/* timer8_counter_compare_unit.sv */
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module timer8_counter_compare_unit (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // Interrupt acknowledge from the core
  input  wire logic       ovf_irq_ack,
  input  wire logic       cmp_irq_ack,
  // Prescaled io clock tick and oscillator pins
  input  wire logic       io_clock,
  input  wire logic       oscillator_pin_one,
  output var  logic       oscillator_pin_two,
  // Interrupt requests
  output var  logic       ovf_irq,
  output var  logic       cmp_irq,
  // Compare output pin
  output var  logic       pin_out,
  output var  logic       pin_oe
);

  // ==========================================================
  // Registers
  logic [2:0] clock_select_field_ff;
  logic [1:0] waveform_mode_field_ff;
  logic [1:0] output_action_field_ff;
  logic       async_clock_select_ff;
  logic [7:0] counter_value_ff;
  logic [7:0] compare_value_ff;
  logic [7:0] compare_buf_ff;
  logic       overflow_flag_ff;
  logic       compare_match_flag_ff;
  logic       ovf_irq_enable_ff;
  logic       compare_irq_enable_ff;
  logic       port_data_ff;
  logic       output_pin_direction_bit_ff;
  logic       compare_output_ff;
  logic       count_down_ff;
  logic       block_ff;
  logic [2:0] osc_sync_ff;
  logic       io_sync_a_ff;
  logic       io_sync_b_ff;
  logic       io_sync_c_ff;
  logic       io_prev_ff;
  logic       osc_prev_ff;

  // ==========================================================
  // Decode helpers
  function automatic logic is_pwm(input logic [1:0] w);
    return (w == timer8_pkg::wgm_pc_pwm) || (w == timer8_pkg::wgm_fast);
  endfunction : is_pwm

  function automatic logic hit(input logic [2:0] a, input logic [2:0] want);
    return a == want;
  endfunction : hit

  logic wr_ctrl;
  logic wr_count;
  logic wr_cmp;
  logic wr_flag;
  logic wr_irq;
  logic wr_async;
  logic wr_pin;
  assign wr_ctrl  = reg_wr && hit(reg_addr, timer8_pkg::ctrl_addr);
  assign wr_count = reg_wr && hit(reg_addr, timer8_pkg::count_addr);
  assign wr_cmp   = reg_wr && hit(reg_addr, timer8_pkg::compare_addr);
  assign wr_flag  = reg_wr && hit(reg_addr, timer8_pkg::flag_addr);
  assign wr_irq   = reg_wr && hit(reg_addr, timer8_pkg::irq_enable_addr);
  assign wr_async = reg_wr && hit(reg_addr, timer8_pkg::async_addr);
  assign wr_pin   = reg_wr && hit(reg_addr, timer8_pkg::pin_addr);

  // ==========================================================
  // Tick generation
  // Both sources cross from outside; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_sync_ff  <= 3'h0;
      io_sync_a_ff <= 1'b0;
      io_sync_b_ff <= 1'b0;
      io_sync_c_ff <= 1'b0;
      io_prev_ff   <= 1'b0;
      osc_prev_ff  <= 1'b0;
    end
    else
    begin
      osc_sync_ff  <= {osc_sync_ff[1:0], oscillator_pin_one};
      io_sync_a_ff <= io_clock;
      io_sync_b_ff <= io_sync_a_ff;
      io_sync_c_ff <= io_sync_b_ff;
      if (io_sync_b_ff == io_sync_c_ff)
        io_prev_ff <= io_sync_c_ff;
      if (osc_sync_ff[1] == osc_sync_ff[2])
        osc_prev_ff <= osc_sync_ff[2];
    end
  end

  logic io_rise;
  logic osc_rise;
  logic src_tick;
  logic timer_tick;
  assign io_rise  = io_sync_b_ff && io_sync_c_ff && !io_prev_ff;
  assign osc_rise = osc_sync_ff[1] && osc_sync_ff[2] && !osc_prev_ff;
  assign src_tick = async_clock_select_ff ? osc_rise : io_rise;
  assign timer_tick = src_tick && (clock_select_field_ff != 3'h0);

  // Feedback pin driven with the inverted third sync stage of the oscillator input
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      oscillator_pin_two <= 1'b0;
    else
      oscillator_pin_two <= !osc_sync_ff[2];
  end

  // ==========================================================
  // Counter control
  wire timer8_pkg::wgm_t mode = timer8_pkg::wgm_t'(waveform_mode_field_ff);
  logic at_top;
  logic at_bottom;
  logic raw_match;
  logic match_now;
  assign at_top    = counter_value_ff == timer8_pkg::count_max;
  assign at_bottom = counter_value_ff == timer8_pkg::count_bot;
  assign raw_match = counter_value_ff == compare_value_ff;
  // A counter write suppresses the match seen on the next tick
  assign match_now = raw_match && !block_ff && !wr_count;

  logic [7:0] nxt_count;
  logic       nxt_down;
  logic       set_ovf;
  logic       reload;
  always_comb
  begin
    nxt_count = counter_value_ff;
    nxt_down  = count_down_ff;
    set_ovf   = 1'b0;
    reload    = 1'b0;
    case (mode)
      timer8_pkg::wgm_normal:
      begin
        nxt_count = counter_value_ff + 8'h01;
        nxt_down  = 1'b0;
        set_ovf   = at_top;
      end
      timer8_pkg::wgm_ctc:
      begin
        nxt_down = 1'b0;
        if (match_now)
          nxt_count = timer8_pkg::count_bot;
        else
          nxt_count = counter_value_ff + 8'h01;
        set_ovf = at_top && !match_now;
      end
      timer8_pkg::wgm_fast:
      begin
        nxt_count = counter_value_ff + 8'h01;
        nxt_down  = 1'b0;
        set_ovf   = at_top;
        reload    = at_top;
      end
      default:
      begin
        // Dual slope turns at both extremes
        if (at_top)
          nxt_down = 1'b1;
        else if (at_bottom)
          nxt_down = 1'b0;
        if ((at_top || count_down_ff) && !at_bottom)
          nxt_count = counter_value_ff - 8'h01;
        else
          nxt_count = counter_value_ff + 8'h01;
        set_ovf = at_bottom && count_down_ff;
        reload  = at_top;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      counter_value_ff <= timer8_pkg::reg_reset;
      count_down_ff    <= 1'b0;
    end
    else if (wr_count)
      counter_value_ff <= reg_wdata;
    else if (timer_tick)
    begin
      counter_value_ff <= nxt_count;
      count_down_ff    <= nxt_down;
    end
  end

  // Block holds until a tick passes, so it survives a stopped timer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      block_ff <= 1'b0;
    else if (wr_count)
      block_ff <= 1'b1;
    else if (timer_tick)
      block_ff <= 1'b0;
  end

  // ==========================================================
  // Compare value and its buffer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      compare_value_ff <= timer8_pkg::reg_reset;
      compare_buf_ff   <= timer8_pkg::reg_reset;
    end
    else
    begin
      if (wr_cmp)
        compare_buf_ff <= reg_wdata;
      if (!is_pwm(waveform_mode_field_ff))
      begin
        if (wr_cmp)
          compare_value_ff <= reg_wdata;
      end
      else if (timer_tick && reload)
        compare_value_ff <= compare_buf_ff;
    end
  end

  // ==========================================================
  // Flags; a set wins over a same-cycle clear
  logic ovf_set;
  logic ocf_set;
  assign ovf_set = timer_tick && set_ovf && !wr_count;
  // Match seen during this count value lands on the tick that leaves it
  assign ocf_set = timer_tick && match_now;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      overflow_flag_ff <= 1'b0;
    else if (ovf_set)
      overflow_flag_ff <= 1'b1;
    else if (ovf_irq_ack || (wr_flag && reg_wdata[timer8_pkg::ovf_pos]))
      overflow_flag_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      compare_match_flag_ff <= 1'b0;
    else if (ocf_set)
      compare_match_flag_ff <= 1'b1;
    else if (cmp_irq_ack || (wr_flag && reg_wdata[timer8_pkg::ocf_pos]))
      compare_match_flag_ff <= 1'b0;
  end

  // ==========================================================
  // Compare output state
  logic force_hit;
  logic act;
  logic nxt_oc;
  // Force is ignored in PWM modes and never stored
  assign force_hit = wr_ctrl && reg_wdata[timer8_pkg::foc_pos]
                     && !is_pwm({reg_wdata[timer8_pkg::wgm1_pos], reg_wdata[timer8_pkg::wgm0_pos]});
  assign act = force_hit || (timer_tick && match_now);

  always_comb
  begin
    nxt_oc = compare_output_ff;
    case (force_hit ? reg_wdata[timer8_pkg::com_lsb +: 2] : output_action_field_ff)
      2'h0: nxt_oc = compare_output_ff;
      2'h1: nxt_oc = is_pwm(waveform_mode_field_ff) && !force_hit
                     ? compare_output_ff : !compare_output_ff;
      2'h2: nxt_oc = is_pwm(waveform_mode_field_ff) && !force_hit
                     ? count_down_ff : 1'b0;
      default: nxt_oc = is_pwm(waveform_mode_field_ff) && !force_hit
                     ? !count_down_ff : 1'b1;
    endcase
  end

  // Control writes change this flop only by a force in a non-PWM mode
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      compare_output_ff <= 1'b0;
    else if (act)
      compare_output_ff <= nxt_oc;
    else if (timer_tick && mode == timer8_pkg::wgm_fast && at_top
             && output_action_field_ff[1])
      compare_output_ff <= !output_action_field_ff[0];
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      clock_select_field_ff       <= 3'h0;
      waveform_mode_field_ff      <= 2'h0;
      output_action_field_ff      <= 2'h0;
      async_clock_select_ff       <= 1'b0;
      ovf_irq_enable_ff           <= 1'b0;
      compare_irq_enable_ff       <= 1'b0;
      port_data_ff                <= 1'b0;
      output_pin_direction_bit_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        clock_select_field_ff  <= reg_wdata[timer8_pkg::cs_lsb +: 3];
        waveform_mode_field_ff <= {reg_wdata[timer8_pkg::wgm1_pos], reg_wdata[timer8_pkg::wgm0_pos]};
        output_action_field_ff <= reg_wdata[timer8_pkg::com_lsb +: 2];
      end
      if (wr_async)
        async_clock_select_ff <= reg_wdata[timer8_pkg::as_pos];
      if (wr_irq)
      begin
        ovf_irq_enable_ff     <= reg_wdata[timer8_pkg::ovie_pos];
        compare_irq_enable_ff <= reg_wdata[timer8_pkg::ocie_pos];
      end
      if (wr_pin)
      begin
        port_data_ff                <= reg_wdata[timer8_pkg::port_pos];
        output_pin_direction_bit_ff <= reg_wdata[timer8_pkg::ddr_pos];
      end
    end
  end

  // ==========================================================
  // Read port and outputs
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    if (reg_addr == timer8_pkg::ctrl_addr)
      rd_mux = {1'b0, waveform_mode_field_ff[1], output_action_field_ff,
                waveform_mode_field_ff[0], clock_select_field_ff};
    else if (reg_addr == timer8_pkg::count_addr)
      rd_mux = counter_value_ff;
    else if (reg_addr == timer8_pkg::compare_addr)
      rd_mux = is_pwm(waveform_mode_field_ff) ? compare_buf_ff : compare_value_ff;
    else if (reg_addr == timer8_pkg::flag_addr)
      rd_mux = {6'h00, compare_match_flag_ff, overflow_flag_ff};
    else if (reg_addr == timer8_pkg::irq_enable_addr)
      rd_mux = {6'h00, compare_irq_enable_ff, ovf_irq_enable_ff};
    else if (reg_addr == timer8_pkg::async_addr)
      rd_mux = {7'h00, async_clock_select_ff};
    else if (reg_addr == timer8_pkg::pin_addr)
      rd_mux = {5'h00, compare_output_ff, output_pin_direction_bit_ff, port_data_ff};
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      ovf_irq   <= 1'b0;
      cmp_irq   <= 1'b0;
      pin_out   <= 1'b0;
      pin_oe    <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      ovf_irq   <= overflow_flag_ff && ovf_irq_enable_ff;
      cmp_irq   <= compare_match_flag_ff && compare_irq_enable_ff;
      pin_out   <= (output_action_field_ff != 2'h0) ? compare_output_ff : port_data_ff;
      pin_oe    <= output_pin_direction_bit_ff;
    end
  end

endmodule : timer8_counter_compare_unit

`default_nettype wire

/* timer8_pkg.sv */
package timer8_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [2:0] ctrl_addr        = 3'h0;
  localparam logic [2:0] count_addr       = 3'h1;
  localparam logic [2:0] compare_addr     = 3'h2;
  localparam logic [2:0] flag_addr        = 3'h3;
  localparam logic [2:0] irq_enable_addr  = 3'h4;
  localparam logic [2:0] async_addr       = 3'h5;
  localparam logic [2:0] pin_addr         = 3'h6;

  // ==========================================================
  // Control register fields
  localparam int cs_lsb      = 0;
  localparam int wgm0_pos    = 3;
  localparam int com_lsb     = 4;
  localparam int wgm1_pos    = 6;
  localparam int foc_pos     = 7;
  // Flag register fields
  localparam int ovf_pos     = 0;
  localparam int ocf_pos     = 1;
  // Irq enable fields
  localparam int ovie_pos    = 0;
  localparam int ocie_pos    = 1;
  // Async register field
  localparam int as_pos      = 0;
  // Pin register fields
  localparam int port_pos    = 0;
  localparam int ddr_pos     = 1;

  // ==========================================================
  // Reset values and counter extremes
  localparam logic [7:0] reg_reset  = 8'h00;
  localparam logic [7:0] count_max  = 8'hff;
  localparam logic [7:0] count_bot  = 8'h00;

  typedef enum logic [1:0] {
    wgm_normal = 2'h0,
    wgm_pc_pwm = 2'h1,
    wgm_ctc    = 2'h2,
    wgm_fast   = 2'h3
  } wgm_t;

endpackage : timer8_pkg

/* timer8_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module timer8_sva (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Acknowledges and oscillator
  input wire logic       ovf_irq_ack,
  input wire logic       cmp_irq_ack,
  input wire logic       oscillator_pin_one,
  input wire logic       oscillator_pin_two,
  // Outputs
  input wire logic       ovf_irq,
  input wire logic       cmp_irq,
  input wire logic       pin_out,
  input wire logic       pin_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  localparam logic [2:0] pin_a = timer8_pkg::pin_addr;
  // Action field copy; the port bypass check is only fair while it is zero
  logic [1:0] com_ff;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      com_ff <= 2'h0;
    else if (reg_wr && reg_addr == timer8_pkg::ctrl_addr)
      com_ff <= reg_wdata[timer8_pkg::com_lsb +: 2];
  end
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_force_reads_zero: assert property (
    reg_rd && reg_addr == timer8_pkg::ctrl_addr |=> !reg_rdata[timer8_pkg::foc_pos])
    else $error("force strobe reads back set");
  a_dir_follows: assert property (
    reg_wr && reg_addr == pin_a |-> ##2 pin_oe == $past(reg_wdata[timer8_pkg::ddr_pos], 2))
    else $error("pin enable not following direction bit");
  a_port_bypass: assert property (
    reg_wr && reg_addr == pin_a && com_ff == 2'h0 |-> ##2 pin_out == $past(reg_wdata[timer8_pkg::port_pos], 2))
    else $error("pin not driven from port bit");
  a_irq_masked: assert property (
    reg_wr && reg_addr == timer8_pkg::irq_enable_addr && !reg_wdata[timer8_pkg::ocie_pos] |-> ##2 !cmp_irq)
    else $error("compare request while disabled");
  a_flag_w1c: assert property (
    reg_wr && reg_addr == timer8_pkg::flag_addr && reg_wdata[timer8_pkg::ocf_pos] |-> ##2 !cmp_irq)
    else $error("compare flag not cleared by write");
  a_ovf_ack: assert property (ovf_irq_ack |-> ##2 !ovf_irq)
    else $error("overflow flag not cleared by ack");
  a_cmp_ack: assert property (cmp_irq_ack |-> ##2 !cmp_irq)
    else $error("compare flag not cleared by ack");
  a_reset_quiet: assert property ($past(rst) |-> !ovf_irq && !cmp_irq && !pin_oe && !pin_out)
    else $error("outputs active after reset");
  a_osc_feedback: assert property ($rose(oscillator_pin_one) |-> ##[1:5] !oscillator_pin_two)
    else $error("oscillator feedback not inverted");
endmodule : timer8_sva

bind timer8_counter_compare_unit timer8_sva timer8_sva_inst (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ovf_irq_ack(ovf_irq_ack), .cmp_irq_ack(cmp_irq_ack),
  .oscillator_pin_one(oscillator_pin_one), .oscillator_pin_two(oscillator_pin_two),
  .ovf_irq(ovf_irq), .cmp_irq(cmp_irq), .pin_out(pin_out), .pin_oe(pin_oe)
);
`default_nettype wire
